// [verilog/serial_loopback_diagnostics.sv]
/*
  Asynchronous serial adapter with echo support for remote loop-back, behind an AHB-Lite slave.
  Assumes modem pins synchronous to hclk; any local loop-back gating sits outside this block.
*/
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`include "serial_loopback_regs.svh"

module serial_loopback_diagnostics
  import serial_loopback_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // External x16 bit clocks
  input  wire logic        tx_bit_clock_x16,
  input  wire logic        rx_bit_clock_x16,
  // Modem side
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             terminal_ready_n,
  output logic             send_request_n,
  input  wire logic        carrier_detect_n,
  input  wire logic        clear_to_send_n,
  input  wire logic        set_ready_n
);

  // Register state
  logic [7:0]  command_r;
  logic [7:0]  control_r;
  logic [7:0]  rx_data_r;
  logic        rx_full_r;
  logic        overrun_r;
  logic        framing_r;
  // Bus data-phase state
  logic        dph_wr_r;
  logic [7:0]  dph_addr_r;
  logic        addr_ok;
  logic        rd_data_hit;
  logic        wr_pend;
  logic        wr_accept;
  // Baud generation
  logic [`BAUD_CNT_W-1:0] baud_cnt_r;
  logic [`BAUD_CNT_W-1:0] baud_reload;
  logic        int_tick;
  logic        tx_clk_d_r;
  logic        rx_clk_d_r;
  logic        tx_tick;
  logic        rx_tick;
  logic        ext_baud;
  // Receiver
  rx_state_t   rx_state_r;
  logic [3:0]  rx_tcnt_r;
  logic [3:0]  rx_bits_r;
  logic [7:0]  rx_shift_r;
  logic        rx_done;
  // Transmitter
  tx_state_t   tx_state_r;
  logic [3:0]  tx_tcnt_r;
  logic [3:0]  tx_bits_r;
  logic [9:0]  tx_shift_r;
  // FIFO hookup
  logic        echo_push;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;
  logic        fifo_empty;

  // Address phase decode; only whole-word transfers are expected
  assign addr_ok     = hsel & htrans[1] & hready;
  assign rd_data_hit = addr_ok & ~hwrite & (haddr == `REG_DATA_OFS);
  assign hresp       = 1'b0;

  // Bus writes to the data register wait while the FIFO is full or an echo takes the slot
  assign wr_pend   = dph_wr_r & (dph_addr_r == `REG_DATA_OFS);
  assign wr_accept = wr_pend & ~echo_push & fifo_in_ready;
  assign hreadyout = ~(wr_pend & ~wr_accept);

  // Data phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end
    else if (hreadyout)
    begin
      dph_wr_r   <= addr_ok & hwrite;
      dph_addr_r <= haddr;
    end
  end

  // Read data registered at the address phase so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok & ~hwrite)
    begin
      unique case (haddr)
        `REG_DATA_OFS:    hrdata <= {24'h00_0000, rx_data_r};
        `REG_STATUS_OFS:  hrdata <= {24'h00_0000, tx_state_r == TX_SEND, set_ready_n, carrier_detect_n,
                                     fifo_empty, rx_full_r, overrun_r, framing_r, 1'b0};
        `REG_COMMAND_OFS: hrdata <= {24'h00_0000, command_r};
        `REG_CONTROL_OFS: hrdata <= {24'h00_0000, control_r};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command and control writes; the remote set-up is software's job
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      command_r <= `CMD_RESET;
      control_r <= `CTL_RESET;
    end
    else if (dph_wr_r)
    begin
      if (dph_addr_r == `REG_COMMAND_OFS)
        command_r <= hwdata[7:0];
      if (dph_addr_r == `REG_CONTROL_OFS)
        control_r <= hwdata[7:0];
    end
  end

  // Handshake outputs straight from command bits; nothing here loops them back
  assign terminal_ready_n = ~command_r[`CMD_TERM_READY_BIT];
  assign send_request_n   = (command_r[`CMD_TX_CTRL_HI:`CMD_TX_CTRL_LO] == 2'b00);

  // Divisor per baud selection, scaled to x16 ticks; fractional divisors round down
  always_comb
  begin
    unique case (control_r[`CTL_BAUD_HI:`CTL_BAUD_LO])
      4'h1:    baud_reload = 12'(`BAUD_DIV_1 / 16 - 1);
      4'h2:    baud_reload = 12'(`BAUD_DIV_2 / 16 - 1);
      4'h3:    baud_reload = 12'(`BAUD_DIV_3 / 16 - 1);
      4'h4:    baud_reload = 12'(`BAUD_DIV_4 / 16 - 1);
      4'h5:    baud_reload = 12'(`BAUD_DIV_5 / 16 - 1);
      4'h6:    baud_reload = 12'(`BAUD_DIV_6 / 16 - 1);
      4'h7:    baud_reload = 12'(`BAUD_DIV_7 / 16 - 1);
      4'h8:    baud_reload = 12'(`BAUD_DIV_8 / 16 - 1);
      4'h9:    baud_reload = 12'(`BAUD_DIV_9 / 16 - 1);
      4'ha:    baud_reload = 12'(`BAUD_DIV_A / 16 - 1);
      4'hb:    baud_reload = 12'(`BAUD_DIV_B / 16 - 1);
      4'hc:    baud_reload = 12'(`BAUD_DIV_C / 16 - 1);
      4'hd:    baud_reload = 12'(`BAUD_DIV_D / 16 - 1);
      4'he:    baud_reload = 12'(`BAUD_DIV_E / 16 - 1);
      default: baud_reload = 12'(`BAUD_DIV_F / 16 - 1);
    endcase
  end

  // Internal x16 tick divider running on hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      baud_cnt_r <= '0;
    else if (baud_cnt_r == '0)
      baud_cnt_r <= baud_reload;
    else
      baud_cnt_r <= baud_cnt_r - 1'b1;
  end

  // Rising-edge detect on the external bit clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_clk_d_r <= 1'b0;
      rx_clk_d_r <= 1'b0;
    end
    else
    begin
      tx_clk_d_r <= tx_bit_clock_x16;
      rx_clk_d_r <= rx_bit_clock_x16;
    end
  end

  // Selection zero means external clocks; control bit 4 makes the receiver share the transmit tick
  assign ext_baud = (control_r[`CTL_BAUD_HI:`CTL_BAUD_LO] == 4'h0);
  assign int_tick = (baud_cnt_r == '0);
  assign tx_tick  = ext_baud ? (tx_bit_clock_x16 & ~tx_clk_d_r) : int_tick;
  assign rx_tick  = control_r[`CTL_RX_SRC_BIT] ? tx_tick
                                               : (rx_bit_clock_x16 & ~rx_clk_d_r);

  // Receiver: mid-start check, then one sample per sixteen ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state_r <= RX_IDLE;
      rx_tcnt_r  <= 4'h0;
      rx_bits_r  <= 4'h0;
      rx_shift_r <= 8'h00;
    end
    else if (rx_tick)
    begin
      rx_tcnt_r <= rx_tcnt_r + 1'b1;
      unique case (rx_state_r)
        RX_IDLE:
        begin
          rx_tcnt_r <= 4'h0;
          if (!serial_in)
            rx_state_r <= RX_START;
        end
        RX_START:
          if (rx_tcnt_r == `START_MID_TICK)
          begin
            rx_tcnt_r  <= 4'h0;
            rx_bits_r  <= 4'h0;
            rx_state_r <= serial_in ? RX_IDLE : RX_DATA;   // Glitch rejection
          end
        RX_DATA:
          if (rx_tcnt_r == `TICKS_PER_BIT)
          begin
            rx_shift_r <= {serial_in, rx_shift_r[7:1]};
            rx_bits_r  <= rx_bits_r + 1'b1;
            if (rx_bits_r == `DATA_BITS - 4'h1)
              rx_state_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_tcnt_r == `TICKS_PER_BIT)
            rx_state_r <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = rx_tick & (rx_state_r == RX_STOP) & (rx_tcnt_r == `TICKS_PER_BIT);

  // Receive holding register and flags; a new character wins over a read that clears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        rx_data_r <= rx_shift_r;
        rx_full_r <= 1'b1;
        framing_r <= ~serial_in;
      end
      else if (rd_data_hit)
      begin
        rx_full_r <= 1'b0;
        framing_r <= 1'b0;
      end
      // Overrun also covers an echo dropped on a full FIFO
      if ((rx_done & rx_full_r & ~rd_data_hit) | (echo_push & ~fifo_in_ready))
        overrun_r <= 1'b1;
      else if (rd_data_hit)
        overrun_r <= 1'b0;
    end
  end

  // Echo pushes the received character for retransmission, ahead of bus writes
  assign echo_push     = rx_done & command_r[`CMD_ECHO_BIT];
  assign fifo_in_valid = echo_push | wr_pend;
  assign fifo_in_data  = echo_push ? rx_shift_r : hwdata[7:0];

  // Transmit FIFO between bus and shifter
  sync_fifo #(
    .WIDTH (8),
    .DEPTH (8)
  ) tx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .empty     (fifo_empty)
  );

  // The shifter takes a word only while idle and the modem clears to send
  assign fifo_out_ready = (tx_state_r == TX_IDLE) & ~clear_to_send_n;

  // Transmitter: start, eight data bits, stop; sixteen ticks per bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_state_r <= TX_IDLE;
      tx_tcnt_r  <= 4'h0;
      tx_bits_r  <= 4'h0;
      tx_shift_r <= 10'h3ff;
    end
    else
    begin
      unique case (tx_state_r)
        TX_IDLE:
          if (fifo_out_valid & fifo_out_ready)
          begin
            tx_shift_r <= {1'b1, fifo_out_data, 1'b0};
            tx_tcnt_r  <= 4'h0;
            tx_bits_r  <= 4'h0;
            tx_state_r <= TX_SEND;
          end
        TX_SEND:
          if (tx_tick)
          begin
            tx_tcnt_r <= tx_tcnt_r + 1'b1;
            if (tx_tcnt_r == `TICKS_PER_BIT)
            begin
              tx_shift_r <= {1'b1, tx_shift_r[9:1]};
              tx_bits_r  <= tx_bits_r + 1'b1;
              if (tx_bits_r == `FRAME_BITS - 4'h1)
                tx_state_r <= TX_IDLE;
            end
          end
      endcase
    end
  end

  // Line idles at mark; the bit on the line is the shifter's low bit, registered once on hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      serial_out <= 1'b1;
    else
      serial_out <= (tx_state_r == TX_SEND) ? tx_shift_r[0] : 1'b1;
  end

endmodule : serial_loopback_diagnostics

// [pkg/serial_loopback_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the serial adapter.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef SERIAL_LOOPBACK_REGS_SVH
`define SERIAL_LOOPBACK_REGS_SVH

// Byte offsets on the bus
`define REG_DATA_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_COMMAND_OFS   8'h08
`define REG_CONTROL_OFS   8'h0c

// Command register fields
`define CMD_TERM_READY_BIT 0
`define CMD_RX_IRQ_OFF_BIT 1
`define CMD_TX_CTRL_LO     2
`define CMD_TX_CTRL_HI     3
`define CMD_ECHO_BIT       4
`define CMD_RESET          8'h00

// Control register fields
`define CTL_BAUD_LO        0
`define CTL_BAUD_HI        3
`define CTL_RX_SRC_BIT     4
`define CTL_RESET          8'h00

// Status register fields
`define STS_FRAMING_BIT    1
`define STS_OVERRUN_BIT    2
`define STS_RX_FULL_BIT    3
`define STS_TX_EMPTY_BIT   4
`define STS_CARRIER_BIT    5
`define STS_SET_READY_BIT  6
`define STS_TX_BUSY_BIT    7

// Serial timing: 16 bit-clock ticks per bit, sample at mid start bit
`define TICKS_PER_BIT      4'hf
`define START_MID_TICK     4'h7
`define DATA_BITS          4'h8
`define FRAME_BITS         4'ha
`define BAUD_CNT_W         12

// Internal divisors per baud selection, in crystal periods; selection zero uses the pins
`define BAUD_DIV_1         16'h9000
`define BAUD_DIV_2         16'h6000
`define BAUD_DIV_3         16'h4181
`define BAUD_DIV_4         16'h3588
`define BAUD_DIV_5         16'h3000
`define BAUD_DIV_6         16'h1800
`define BAUD_DIV_7         16'h0c00
`define BAUD_DIV_8         16'h0600
`define BAUD_DIV_9         16'h0400
`define BAUD_DIV_A         16'h0300
`define BAUD_DIV_B         16'h0200
`define BAUD_DIV_C         16'h0180
`define BAUD_DIV_D         16'h0100
`define BAUD_DIV_E         16'h00c0
`define BAUD_DIV_F         16'h0060

`endif

// [pkg/serial_loopback_pkg.sv]
/*
  Types shared by the serial adapter design files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_loopback_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

endpackage : serial_loopback_pkg

// [verilog/sync_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides and a registered head word.
  Assumes one clock and an active-low asynchronous reset; total occupancy never passes DEPTH.
*/
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      mem_cnt_r;
  logic             head_valid_r;
  logic [WIDTH-1:0] head_data_r;
  logic             push;
  logic             load;
  logic             pop_head;

  // Total occupancy counts the head register too, so full is honest
  assign in_ready  = ({1'b0, mem_cnt_r} + {{AW+1{1'b0}}, head_valid_r}) < (AW+2)'(DEPTH);
  assign push      = in_valid & in_ready;
  assign pop_head  = head_valid_r & out_ready;
  assign load      = (mem_cnt_r != '0) & (~head_valid_r | pop_head);
  assign out_valid = head_valid_r;
  assign out_data  = head_data_r;
  assign empty     = ~head_valid_r & (mem_cnt_r == '0);

  // Storage writes; no reset needed on the array
  always_ff @(posedge hclk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      mem_cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (load)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      mem_cnt_r <= mem_cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // Head register keeps read data coming from a flip-flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      head_valid_r <= 1'b0;
      head_data_r  <= '0;
    end
    else if (load)
    begin
      head_valid_r <= 1'b1;
      head_data_r  <= mem_r[rd_ptr_r];
    end
    else if (pop_head)
      head_valid_r <= 1'b0;
  end

endmodule : sync_fifo

// [sim/serial_loopback_diagnostics_properties.sv]
/*
  Concurrent checks on the serial adapter's bus and line ports.
  Assumes one clock, hclk, and the active-low reset hresetn; bound to every instance.
*/
module serial_loopback_diagnostics_properties (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Line
  input wire logic        tx_bit_clock_x16,
  input wire logic        serial_out,
  input wire logic        terminal_ready_n,
  input wire logic        send_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       tk_p_r;
  logic       so_p_r;
  logic       dw_r;
  logic [7:0] tcnt_r;

  // Ticks since the line last moved; a low run must end on a 16-tick boundary
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tk_p_r <= 1'b0;
      so_p_r <= 1'b1;
      tcnt_r <= 8'h00;
    end
    else
    begin
      tk_p_r <= tx_bit_clock_x16;
      so_p_r <= serial_out;
      if (serial_out != so_p_r)
        tcnt_r <= 8'h00;
      else if (tx_bit_clock_x16 && !tk_p_r)
        tcnt_r <= tcnt_r + 8'h01;
    end

  // Data phase of a data-register write is the only place a wait may come from
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dw_r <= 1'b0;
    else if (hready)
      dw_r <= hsel && htrans[1] && hwrite && haddr == 8'h00;

  sequence cmd_wr_s;
    hsel && htrans[1] && hready && hwrite && haddr == 8'h08 ##1 hready;
  endsequence

  chk_reset_idle: assert property (disable iff (1'b0) !hresetn |-> serial_out && terminal_ready_n
    && send_request_n && hreadyout && hrdata == 32'h0)
    else $error("outputs not idle in reset");
  chk_bit_span: assert property ($rose(serial_out) |-> tcnt_r >= 8'h0f
    && ((tcnt_r + 8'h01) & 8'h0f) <= 8'h02)
    else $error("low run on the line is not whole bits of 16 ticks");
  chk_dtr_follow: assert property (cmd_wr_s |=> terminal_ready_n == !$past(hwdata[0]))
    else $error("terminal ready pin does not follow command bit 0");
  chk_rts_follow: assert property (cmd_wr_s |=> send_request_n == ($past(hwdata[3:2]) == 2'b00))
    else $error("send request pin does not follow command bits 3 to 2");
  chk_wait_cause: assert property (!hreadyout |-> dw_r)
    else $error("wait state outside a data-register write");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response is not OKAY");
  chk_rdata_lanes: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
endmodule : serial_loopback_diagnostics_properties

bind serial_loopback_diagnostics serial_loopback_diagnostics_properties chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata,
  .hresp, .tx_bit_clock_x16, .serial_out, .terminal_ready_n, .send_request_n);

// [sim/modem_link_model.sv]
/*
  Modem and local loop-back gating model at the adapter's line side.
  Assumes hclk-synchronous line levels; the bench drives the select and the modem levels.
*/
module modem_link_model (
  // Clock and select
  input  wire logic hclk,
  input  wire logic loop_sel,
  // Adapter side
  input  wire logic dev_txd,
  input  wire logic dev_dtr_n,
  input  wire logic dev_rts_n,
  output logic      dev_rxd,
  output logic      dev_dcd_n,
  output logic      dev_cts_n,
  output logic      dev_dsr_n,
  // Line side
  output logic      line_txd,
  output logic      line_dtr_n,
  output logic      line_rts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mdm_rxd   = 1'b1;
  logic mdm_dcd_n = 1'b0;
  logic mdm_cts_n = 1'b0;
  logic mdm_dsr_n = 1'b0;

  // High select parks the line at idle so the far end sees nothing
  assign line_txd   = loop_sel ? 1'b1 : dev_txd;
  assign line_dtr_n = loop_sel ? 1'b1 : dev_dtr_n;
  assign line_rts_n = loop_sel ? 1'b1 : dev_rts_n;
  // Modem levels are ignored while looped; outputs come home instead and set ready is held low
  assign dev_rxd    = loop_sel ? dev_txd : mdm_rxd;
  assign dev_dcd_n  = loop_sel ? dev_dtr_n : mdm_dcd_n;
  assign dev_cts_n  = loop_sel ? dev_rts_n : mdm_cts_n;
  assign dev_dsr_n  = loop_sel ? 1'b0 : mdm_dsr_n;

  // One 8N1 character, bp cycles a bit; call just after an edge
  task automatic send_char(input logic [7:0] b, input int bp);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      mdm_rxd <= f[i];
      repeat (bp) @(posedge hclk);
    end
  endtask : send_char
endmodule : modem_link_model

// [sim/serial_loopback_diagnostics_tb.sv]
/*
  Self-checking bench: bus master tasks, modem model, local and remote loop runs.
  Assumes the package, design files, checker and modem model are compiled first.
*/
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module serial_loopback_diagnostics_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk     = 1'b0;
  logic        hresetn  = 1'b1;
  logic        hsel     = 1'b0;
  logic [7:0]  haddr    = 8'h00;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        loop_sel = 1'b0;
  logic        leak     = 1'b0;
  logic [1:0]  tdiv_r   = 2'h0;
  logic [2:0]  rdiv_r   = 3'h0;
  logic        hreadyout, hresp, serial_out, terminal_ready_n, send_request_n;
  logic        rxd, dcd_n, cts_n, dsr_n, line_txd, line_dtr_n, line_rts_n;
  logic [31:0] hrdata;
  logic [7:0]  cmds [5] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0c};
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc_cnt   = 0;

  always #50 hclk = ~hclk;

  // External x16 clocks: transmit every 4 cycles, receive every 6
  always @(posedge hclk)
  begin
    tdiv_r <= tdiv_r + 2'h1;
    rdiv_r <= (rdiv_r == 3'h5) ? 3'h0 : rdiv_r + 3'h1;
  end

  serial_loopback_diagnostics dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .tx_bit_clock_x16(tdiv_r[1]),
    .rx_bit_clock_x16(rdiv_r < 3'h3), .serial_in(rxd), .serial_out, .terminal_ready_n,
    .send_request_n, .carrier_detect_n(dcd_n), .clear_to_send_n(cts_n), .set_ready_n(dsr_n));

  modem_link_model mdl_u (
    .hclk, .loop_sel, .dev_txd(serial_out), .dev_dtr_n(terminal_ready_n),
    .dev_rts_n(send_request_n), .dev_rxd(rxd), .dev_dcd_n(dcd_n), .dev_cts_n(cts_n),
    .dev_dsr_n(dsr_n), .line_txd, .line_dtr_n, .line_rts_n);

  task test_done;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Watchdog, and a sticky flag for any line_txd activity while looped
  always @(posedge hclk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (loop_sel && line_txd !== 1'b1)
      leak <= 1'b1;
    if (cyc_cnt == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // Single word transfer; each phase held until hready is seen high
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk iff hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk iff hreadyout);
    rd = hrdata;
  endtask : bus_xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus_xfer(1'b1, a, wd, x);
  endtask : bus_wr

  // Samples one frame off the line at mid-bit, bp cycles a bit
  task automatic get_frame(input int bp, output logic [7:0] b);
    @(negedge line_txd);
    repeat (bp / 2) @(posedge hclk);
    `CHK("start", 1'b0, line_txd)
    for (int i = 0; i < 8; i++)
    begin
      repeat (bp) @(posedge hclk);
      b[i] = line_txd;
    end
    repeat (bp) @(posedge hclk);
    `CHK("stop", 1'b1, line_txd)
  endtask : get_frame

  initial
  begin
    logic [31:0] d;
    logic [7:0]  b;
    logic [7:0]  g;
    logic [7:0]  q [9];
    // A real falling edge at time zero, so the asynchronous resets act before the first clock
    hresetn <= 1'b0;
    void'($urandom(81365));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped hole, handshake pins with select low
    bus_xfer(1'b0, 8'h08, 32'h0, d);
    `CHK("cmd", 32'h0, d)
    bus_xfer(1'b0, 8'h0c, 32'h0, d);
    `CHK("ctl", 32'h0, d)
    bus_wr(8'h20, 32'hff);
    bus_xfer(1'b0, 8'h20, 32'h0, d);
    `CHK("hole", 32'h0, d)
    foreach (cmds[i])
    begin
      bus_wr(8'h08, {24'h0, cmds[i]});
      @(posedge hclk);
      `CHK("pins", {~cmds[i][0], cmds[i][3:2] == 2'h0}, {line_dtr_n, line_rts_n})
    end
    // Plain transmit with clear-to-send held off: eight words fill the FIFO, the ninth waits
    // in its data phase until the shifter takes the head; frames then leave in order
    mdl_u.mdm_cts_n <= 1'b1;
    foreach (q[i])
      q[i] = 8'($urandom);
    for (int i = 0; i < 8; i++)
      bus_wr(8'h00, {24'h0, q[i]});
    fork
      bus_wr(8'h00, {24'h0, q[8]});
      begin
        repeat (4) @(posedge hclk);
        `CHK("wait", 1'b0, hreadyout)
        mdl_u.mdm_cts_n <= 1'b0;
        get_frame(64, g);
        `CHK("tx", q[0], g)
      end
    join
    for (int i = 1; i < 9; i++)
    begin
      get_frame(64, g);
      `CHK("tx", q[i], g)
    end
    bus_xfer(1'b0, 8'h04, 32'h0, d);
    `CHK("rxf", 1'b0, d[3])
    // Receive on the slower external clock, then on the internal divider's top selection
    // with the receiver on the transmit tick: both give 96 cycles a bit
    for (int i = 0; i < 2; i++)
    begin
      bus_wr(8'h0c, (i == 0) ? 32'h00 : 32'h1f);
      b = 8'($urandom);
      mdl_u.send_char(b, 96);
      repeat (12) @(posedge hclk);
      bus_xfer(1'b0, 8'h00, 32'h0, d);
      `CHK("rx", {24'h0, b}, d)
    end
    // Local loop with the modem shouting: held until send request returns as clear
    mdl_u.mdm_rxd   <= 1'b0;
    mdl_u.mdm_dcd_n <= 1'b1;
    mdl_u.mdm_cts_n <= 1'b1;
    mdl_u.mdm_dsr_n <= 1'b1;
    loop_sel        <= 1'b1;
    bus_wr(8'h0c, 32'h10);
    bus_wr(8'h08, 32'h01);
    b = 8'($urandom);
    bus_wr(8'h00, {24'h0, b});
    repeat (700) @(posedge hclk);
    bus_xfer(1'b0, 8'h04, 32'h0, d);
    `CHK("held", 5'h00, d[7:3])
    bus_wr(8'h08, 32'h09);
    repeat (700) @(posedge hclk);
    bus_xfer(1'b0, 8'h00, 32'h0, d);
    `CHK("loop", {24'h0, b}, d)
    `CHK("line", 3'h3, {leak, line_dtr_n, line_rts_n})
    loop_sel        <= 1'b0;
    mdl_u.mdm_dsr_n <= 1'b0;
    mdl_u.mdm_rxd   <= 1'b1;
    mdl_u.mdm_dcd_n <= 1'b0;
    mdl_u.mdm_cts_n <= 1'b0;
    // Remote loop: echo with send request on, corner bytes then a random one
    bus_wr(8'h08, 32'h19);
    for (int i = 0; i < 3; i++)
    begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      fork
        mdl_u.send_char(b, 64);
        get_frame(64, g);
      join
      `CHK("echo", b, g)
    end
    test_done();
  end
endmodule : serial_loopback_diagnostics_tb
